// ==== hdl/tmc_counter_ctrl.sv ====
// counter control block: APB control register, source select, prescaler, count
// assumes one clock clk_sys at 125 MHz; external pin and slow oscillator are asynchronous
// Notes on behaviour
// (RL1) two-bit field picks four count sources
// (RL2) external pin counts on rising edges
// (RL3) prescaler divides by one, two, four, eight
// (RL4) sync bit clear synchronises async input
// (RL5) on bit runs counter; off clears gate
// (RL6) bits three and one read zero
// (RL7) enabled counter increments once per tick
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_params.svh"
module tmc_counter_ctrl (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TMC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_pin,
  input wire logic low_freq_internal_osc,
  input wire logic gate_set,
  output logic counter_running,
  output logic [`TMC_CNT_W-1:0] count_value,
  output logic gate_state
);
  logic [7:0] ctrlQ;
  logic [7:0] ctrlD;
  logic [`TMC_CNT_W-1:0] countQ;
  logic gateQ;
  logic [1:0] fosc4Q;
  logic [`TMC_PS_W-1:0] psQ;
  logic [31:0] rdataQ;
  logic readyQ;
  logic errQ;
  logic runQ;
  logic pinLevel;
  logic pinRise;
  logic oscLevel;
  logic oscRise;
  logic pinRawQ;
  logic oscRawQ;
  logic pinRawRise;
  logic oscRawRise;
  // bus decode
  wire access = psel && penable && !readyQ;
  wire selCtrl = paddr == `TMC_OFF_CTRL;
  wire selCount = paddr == `TMC_OFF_COUNT;
  wire selGate = paddr == `TMC_OFF_GATE;
  wire mapped = selCtrl || selCount || selGate;
  // writes land only on the completing edge, when pready is seen high with the request
  wire wrDone = psel && penable && readyQ && pwrite;
  wire ctrlWrite = wrDone && selCtrl && pstrb[0];
  wire cntWrite = wrDone && selCount;
  wire gateWrite = wrDone && selGate;
  // (RL6) reserved bits masked
  assign ctrlD = pwdata[7:0] & `TMC_CTRL_WMASK;
  // control fields
  wire [1:0] srcSel = ctrlQ[`TMC_SRC_HI:`TMC_SRC_LO];
  wire [1:0] psSel = ctrlQ[`TMC_PS_HI:`TMC_PS_LO];
  wire syncBypass = ctrlQ[`TMC_SYNC_BIT];
  wire counterOn = ctrlQ[`TMC_ON_BIT];
  // (RL2) pin rising edge
  tmc_sync3 pinSync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(clk_en),
    .d(external_count_pin),
    .level(pinLevel),
    .rise(pinRise)
  );
  tmc_sync3 oscSync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(clk_en),
    .d(low_freq_internal_osc),
    .level(oscLevel),
    .rise(oscRise)
  );
  // unsynchronised edge detect: latency traded for metastability exposure
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pinRawQ <= 1'b0;
      oscRawQ <= 1'b0;
    end else if (clk_en) begin
      pinRawQ <= external_count_pin;
      oscRawQ <= low_freq_internal_osc;
    end
  end
  assign pinRawRise = external_count_pin && !pinRawQ;
  assign oscRawRise = low_freq_internal_osc && !oscRawQ;
  // (RL4) choose synchronised or bypass edges
  wire pinTick = syncBypass ? pinRawRise : pinRise;
  wire oscTick = syncBypass ? oscRawRise : oscRise;
  // (RL1) source selection
  wire srcTick = (srcSel == tmc_pkg::TMC_SRC_INSTR) ? (fosc4Q == `TMC_FOSC4_DIV) :
                 (srcSel == tmc_pkg::TMC_SRC_SYS) ? 1'b1 :
                 (srcSel == tmc_pkg::TMC_SRC_PIN) ? pinTick : oscTick;
  // (RL3) prescale terminal count
  wire [`TMC_PS_W-1:0] psMask = (psSel == 2'h0) ? 3'h0 : (psSel == 2'h1) ? 3'h1 :
                                (psSel == 2'h2) ? 3'h3 : 3'h7;
  wire psTick = srcTick && ((psQ & psMask) == psMask);
  // instruction clock divider runs freely
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fosc4Q <= 2'h0;
    end else if (clk_en) begin
      fosc4Q <= fosc4Q + 2'h1;
    end
  end
  // (RL3) prescaler counts source ticks, held clear while off
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      psQ <= 3'h0;
    end else if (clk_en) begin
      if (!counterOn || ctrlWrite) begin
        psQ <= 3'h0;
      end else if (srcTick) begin
        psQ <= psTick ? 3'h0 : psQ + 3'h1;
      end
    end
  end
  // (RL7) count one per prescaler tick
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      countQ <= `TMC_CNT_RESET;
    end else if (clk_en) begin
      if (cntWrite) begin
        countQ <= pwdata[`TMC_CNT_W-1:0];
      end else if (counterOn && psTick) begin
        countQ <= countQ + `TMC_COUNT_ONE;
      end
    end
  end
  // (RL5) off clears gate; set wins over software clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gateQ <= 1'b0;
    end else if (clk_en) begin
      if (!counterOn) begin
        gateQ <= 1'b0;
      end else if (gate_set) begin
        gateQ <= 1'b1;
      end else if (gateWrite) begin
        gateQ <= pwdata[0];
      end
    end
  end
  // control register and APB answer, one wait state per access
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrlQ <= `TMC_CTRL_RESET;
      rdataQ <= 32'h0000_0000;
      readyQ <= 1'b0;
      errQ <= 1'b0;
      runQ <= 1'b0;
    end else if (clk_en) begin
      readyQ <= access;
      errQ <= access && !mapped;
      runQ <= counterOn;
      if (ctrlWrite) begin
        ctrlQ <= ctrlD;
      end
      if (access && !pwrite) begin
        rdataQ <= selCtrl ? {24'h00_0000, ctrlQ} :
                  selCount ? {16'h0000, countQ} :
                  selGate ? {31'h0000_0000, gateQ} : 32'h0000_0000;
      end
    end
  end
  assign prdata = rdataQ;
  assign pready = readyQ;
  assign pslverr = errQ;
  assign counter_running = runQ;
  assign count_value = countQ;
  assign gate_state = gateQ;
  // checks
  // (RL6) reserved bits zero
  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!nrst) // (RL6)
    (ctrlQ & ~`TMC_CTRL_WMASK) == 8'h00)
    else $error("reserved control bits not zero");
  // (RL5) off clears gate
  chk_off_gate_clear: assert property (@(posedge clk_sys) disable iff (!nrst) // (RL5)
    (clk_en && !counterOn) |=> !gateQ)
    else $error("gate not cleared while off");
  // (RL5) off stops count
  chk_off_no_count: assert property (@(posedge clk_sys) disable iff (!nrst) // (RL5)
    (clk_en && !counterOn && !cntWrite) |=> $stable(countQ))
    else $error("count moved while off");
  // (RL7) one step per tick
  chk_count_step: assert property (@(posedge clk_sys) disable iff (!nrst) // (RL7)
    (clk_en && counterOn && psTick && !cntWrite)
    |=> countQ == $past(countQ) + `TMC_COUNT_ONE)
    else $error("count did not step by one");
  // (RL3) divide by eight
  chk_sys_div8: assert property (@(posedge clk_sys) disable iff (!nrst) // (RL3)
    (clk_en && counterOn && srcSel == tmc_pkg::TMC_SRC_SYS && psSel == 2'h3 && psTick)
    |=> !psTick [*7])
    else $error("divide by eight ticks too soon");
  // (RL1) quarter-rate instruction clock; a frozen cycle only lengthens the gap
  chk_instr_rate: assert property (@(posedge clk_sys) disable iff (!nrst) // (RL1)
    (clk_en && fosc4Q == `TMC_FOSC4_DIV) |=> (fosc4Q != `TMC_FOSC4_DIV) [*3])
    else $error("instruction clock faster than quarter rate");
  // (RL2) bypass counts only on pin rise
  chk_pin_rising: assert property (@(posedge clk_sys) disable iff (!nrst) // (RL2)
    (clk_en && counterOn && srcSel == tmc_pkg::TMC_SRC_PIN && syncBypass && !cntWrite)
    |=> (countQ == $past(countQ)) || $rose(pinRawQ))
    else $error("pin count without rising edge");
  // (RL4) synchronised pin counts follow the filtered level
  chk_sync_path: assert property (@(posedge clk_sys) disable iff (!nrst) // (RL4)
    (clk_en && counterOn && srcSel == tmc_pkg::TMC_SRC_PIN && !syncBypass && !cntWrite)
    |=> (countQ == $past(countQ)) || $rose(pinLevel))
    else $error("pin count bypassed the synchroniser");
  // (RL4) synchronised oscillator counts follow the filtered level
  chk_osc_sync_path: assert property (@(posedge clk_sys) disable iff (!nrst) // (RL4)
    (clk_en && counterOn && srcSel == tmc_pkg::TMC_SRC_LFOSC && !syncBypass && !cntWrite)
    |=> (countQ == $past(countQ)) || $rose(oscLevel))
    else $error("oscillator count bypassed the synchroniser");
  chk_ready_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && access) |=> pready ##1 !pready)
    else $error("apb ready not a single pulse");
endmodule // tmc_counter_ctrl
`default_nettype wire

// ==== hdl/tmc_sync3.sv ====
// three-stage input synchroniser with agreement filter and rising-edge pulse
// assumes d is asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module tmc_sync3 (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic d,
  output logic level,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  // stage one only feeds stage two; the level moves once stages two and three agree
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end
  assign level = lvl_q;
  assign rise = ce && (s2_q == s3_q) && s3_q && !lvl_q;
endmodule // tmc_sync3
`default_nettype wire

// ==== pkg/tmc_params.svh ====
// constants for the counter control block: register map, field positions, reset values
// assumes an APB slave with 32-bit data and word-aligned registers
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH
`define TMC_ADDR_W 12
`define TMC_OFF_CTRL 12'h000
`define TMC_OFF_COUNT 12'h004
`define TMC_OFF_GATE 12'h008
`define TMC_CTRL_RESET 8'h00
`define TMC_CTRL_WMASK 8'hf5
`define TMC_SRC_HI 7
`define TMC_SRC_LO 6
`define TMC_PS_HI 5
`define TMC_PS_LO 4
`define TMC_SYNC_BIT 2
`define TMC_ON_BIT 0
`define TMC_CNT_W 16
`define TMC_CNT_RESET 16'h0000
`define TMC_COUNT_ONE 16'h0001
`define TMC_FOSC4_DIV 2'h3
`define TMC_PS_W 3
`endif

// ==== pkg/tmc_pkg.sv ====
// types for the counter control block
// assumes tmc_params.svh supplies the numeric constants
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_SRC_INSTR,
    TMC_SRC_SYS,
    TMC_SRC_PIN,
    TMC_SRC_LFOSC
  } tmc_src_type;
endpackage

// ==== tb/test_tmc_counter_ctrl.sv ====
// testbench for the counter control block: apb access, sources, prescaler, gate
// assumes one wait state per apb access and a free-running 125 MHz clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "tmc_params.svh"
module test_tmc_counter_ctrl;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin = 1'b0;
  logic osc = 1'b0;
  logic gateSet = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] strb = 4'hf;
  logic running;
  logic gateState;
  logic [15:0] count;
  logic [31:0] rd;
  logic lastErr;
  int errorCnt = 0;
  int checked = 0;

  // 8 ns period
  always #4 clk_sys = ~clk_sys;

  // clock enable and byte strobes are driven so that freeze and lane gating get exercised
  tmc_counter_ctrl u_tmc_counter_ctrl (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_pin(pin), .low_freq_internal_osc(osc), .gate_set(gateSet),
    .counter_running(running), .count_value(count), .gate_state(gateState));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errorCnt++;
      tally_and_finish;
    end
  endtask

  // reset values, unused control bits, unmapped address
  task automatic t_bits;
    apb(1'b0, `TMC_OFF_CTRL, 32'h0, rd);
    chk(rd, 32'h0);
    apb(1'b0, `TMC_OFF_COUNT, 32'h0, rd);
    chk(rd, 32'h0);
    apb(1'b1, `TMC_OFF_CTRL, 32'hff, rd);
    apb(1'b0, `TMC_OFF_CTRL, 32'h0, rd);
    chk(rd, 32'hf5);
    apb(1'b1, `TMC_OFF_CTRL, 32'h0a, rd);
    apb(1'b0, `TMC_OFF_CTRL, 32'h0, rd);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0, rd);
    chk(rd, 32'h0);
    chk(32'(lastErr), 32'h1);
  endtask

  // instruction and system clock sources at every prescale; window is a multiple of every period
  task automatic t_rate;
    logic [15:0] c0;
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        apb(1'b1, `TMC_OFF_CTRL, {24'h0, s[1:0], p[1:0], 4'h1}, rd);
        @(posedge clk_sys);
        c0 = count;
        repeat (128) @(posedge clk_sys);
        chk(32'(count - c0), 32'((128 >> p) / (s == 0 ? 4 : 1)));
      end
    end
  endtask

  // five slow pulses on pin or oscillator: only rising edges count
  task automatic t_edges(input logic [1:0] s, input logic sy);
    logic [15:0] c0;
    apb(1'b1, `TMC_OFF_CTRL, {24'h0, s, 2'b00, 1'b0, sy, 2'b01}, rd);
    repeat (8) @(posedge clk_sys);
    c0 = count;
    for (int i = 0; i < 10; i++) begin
      pin <= s == 2'h2 && !i[0];
      osc <= s == 2'h3 && !i[0];
      repeat (2) @(posedge clk_sys);
      // bypass counts at once, synchronised path is still in flight
      if (i == 0) chk(32'(count - c0), {31'h0, sy});
      // a falling edge must not add a count
      if (i == 1) chk(32'(count - c0), 32'h1);
      repeat (6) @(posedge clk_sys);
    end
    chk(32'(count - c0), 32'h5);
  endtask

  // gate set while on, then off clears gate and stops count
  task automatic t_gate;
    logic [15:0] c0;
    apb(1'b1, `TMC_OFF_CTRL, 32'h41, rd);
    gateSet <= 1'b1;
    @(posedge clk_sys);
    gateSet <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(32'(running), 32'h1);
    apb(1'b0, `TMC_OFF_GATE, 32'h0, rd);
    chk(rd, 32'h1);
    apb(1'b1, `TMC_OFF_CTRL, 32'h40, rd);
    repeat (3) @(posedge clk_sys);
    chk(32'(gateState), 32'h0);
    chk(32'(running), 32'h0);
    c0 = count;
    repeat (20) @(posedge clk_sys);
    chk(32'(count), 32'(c0));
  endtask

  // lane 0 off leaves control alone; clock enable low freezes the count
  task automatic t_freeze;
    logic [15:0] c0;
    apb(1'b1, `TMC_OFF_CTRL, 32'h41, rd);
    strb <= 4'h0;
    apb(1'b1, `TMC_OFF_CTRL, 32'h00, rd);
    strb <= 4'hf;
    apb(1'b0, `TMC_OFF_CTRL, 32'h0, rd);
    chk(rd, 32'h41);
    clkEn <= 1'b0;
    @(posedge clk_sys);
    c0 = count;
    repeat (10) @(posedge clk_sys);
    chk(32'(count), 32'(c0));
    clkEn <= 1'b1;
    repeat (9) @(posedge clk_sys);
    chk(32'(count - c0), 32'h8);
  endtask

  // reset in mid-run clears count and controls; first access right after release
  task automatic t_reset;
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(32'(count), 32'h0);
    chk(32'(running), 32'h0);
    nrst <= 1'b1;
    apb(1'b0, `TMC_OFF_CTRL, 32'h0, rd);
    chk(rd, 32'h0);
  endtask

  // reset for 20 cycles, then scenarios
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_bits;
    t_rate;
    t_edges(2'h2, 1'b1);
    t_edges(2'h2, 1'b0);
    t_edges(2'h3, 1'b1);
    t_edges(2'h3, 1'b0);
    t_gate;
    t_freeze;
    t_reset;
    tally_and_finish;
  end
endmodule // test_tmc_counter_ctrl
`default_nettype wire
